// ---- design/odopc_consts.svh ----
/*
 * Constants of the odometer pulse conditioning block: register offsets, field positions, reset values and timing.
 * Assumes it is included by bare name wherever a figure below is needed; it holds definitions only.
 */
`ifndef ODOPC_CONSTS_SVH
`define ODOPC_CONSTS_SVH

// Clock rate in MHz; windows below are given in milliseconds.
`define ODOPC_CLK_MHZ 250
`define ODOPC_RATE_WIN_MS 1000
`define ODOPC_SPEED_WIN_MS 500

// Highest pulse count per rate window that is still accepted.
`define ODOPC_RATE_LIMIT 16'h1388

// Cross-check pulse counts: correlation distance, check span, and fewest pulses a live input must show.
`define ODOPC_CORR_PULSES 8'h3C
`define ODOPC_CHECK_PULSES 8'h3C
`define ODOPC_MISS_PULSES 8'h0F

// Register byte offsets.
`define ODOPC_REG_CTRL 8'h00
`define ODOPC_REG_CMD 8'h04
`define ODOPC_REG_STATUS 8'h08
`define ODOPC_REG_IRQ_STAT 8'h0C
`define ODOPC_REG_IRQ_MASK 8'h10
`define ODOPC_REG_SPEED 8'h14

// Control register fields.
`define ODOPC_CTRL_SEL 0
`define ODOPC_CTRL_FSEL 1
`define ODOPC_CTRL_VIEW 2
`define ODOPC_CTRL_SHIFT 3

// Command register fields, each a one-shot action on write of a one.
`define ODOPC_CMD_STEP 0
`define ODOPC_CMD_SHIFT 1
`define ODOPC_CMD_ADJ 2

// Interrupt status and mask fields.
`define ODOPC_IRQ_FAST 0
`define ODOPC_IRQ_FAIL1 1
`define ODOPC_IRQ_FAIL2 2

// Reset values.
`define ODOPC_RATIO_RST 3'h0
`define ODOPC_CTRL_RST 4'h0
`define ODOPC_MASK_RST 3'h0

`endif

// ---- design/odopc_divider.sv ----
/*
 * Power-of-two pulse divider for the second odometer input.
 * Assumes one-cycle qualified input pulses and a restart pulse whenever the ratio changes.
 */
module odopc_divider
	import odopc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Control.
	input odopc_pkg::odopc_ratio_t ratio_code,
	input wire logic restart,
	// Pulses.
	input wire logic pulse_in,
	output logic pulse_out
);
	import odopc_pkg::*;

	logic [7:0] cnt_ff;
	logic [7:0] last;

	assign last = odopc_ratio_val(ratio_code) - 8'h01;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 8'h00;
			pulse_out <= 1'b0;
		end else if (restart) begin
			cnt_ff <= 8'h00;
			pulse_out <= 1'b0;
		end else if (pulse_in) begin
			if (cnt_ff >= last) begin
				cnt_ff <= 8'h00;
				pulse_out <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
				pulse_out <= 1'b0;
			end
		end else begin
			pulse_out <= 1'b0;
		end
	end
endmodule // odopc_divider

// ---- design/odopc_pkg.sv ----
/*
 * Types and shared arithmetic of the odometer pulse conditioning block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package odopc_pkg;

	typedef logic [2:0] odopc_ratio_t;

	typedef enum logic [1:0] {
		CC_IDLE = 2'b00,
		CC_CORR = 2'b01,
		CC_WATCH = 2'b10
	} odopc_cc_state_t;

	// Division ratio from its code: 1, 2, 4 ... 128.
	function automatic logic [7:0] odopc_ratio_val(input odopc_ratio_t code);
		odopc_ratio_val = 8'h01 << code;
	endfunction

endpackage

// ---- design/odopc_top.sv ----
/*
 * Odometer pulse input conditioning: input edge qualification, divider on the second input, over-rate warning,
 * speed sampling, factor selection, transducer cross-check, register port and interrupt.
 * Assumes pulse inputs synchronous to clk and a plain register port master that never overlaps strobes.
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
// Notes on behaviour
// - Second input pulses are divided by 1, 2, 4, 8, 16, 32, 64 or 128.
// - First input is always undivided and never shows a ratio.
// - Over 5000 pulses per second on the active input raises a too-fast warning.
// - Each ratio-select action steps the second input ratio to another value.
// - Ratio shows only with input two selected, special view and shift held.
// - Duplicate output carries the divided second-input pulses.
// - Each input has its own factor pair, giving four factor choices.
// - Cross-check first correlates both inputs over about 0.03 mile.
// - A disagreement raises a warning naming the failed input.
// - Shift, factor adjustment or input change clears a pending warning.
// - Clearing by shift or adjustment disarms until the input is changed.
// - Speed is sampled from the pulse stream every half second.
`include "odopc_consts.svh"

module odopc_top #(
	parameter int RATE_WIN_CYC = `ODOPC_RATE_WIN_MS * `ODOPC_CLK_MHZ * 1000,
	parameter int SPEED_WIN_CYC = `ODOPC_SPEED_WIN_MS * `ODOPC_CLK_MHZ * 1000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Transducer inputs.
	input wire logic odo1_in,
	input wire logic odo2_in,
	// Register port.
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Pulse outputs.
	output logic dup_pulse_out,
	output logic count_pulse_out,
	// Display indications.
	output logic too_fast_warning,
	output logic first_source_failed_warning,
	output logic second_source_failed_warning,
	output logic ratio_show,
	output logic [7:0] ratio_value,
	output logic [1:0] factor_index,
	// Interrupt.
	output logic irq
);
	import odopc_pkg::*;

	logic prev1_ff;
	logic prev2_ff;
	logic q1;
	logic q2;
	logic div2;
	logic active_pulse;
	logic [3:0] ctrl_ff;
	odopc_ratio_t ratio_ff;
	logic [2:0] mask_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] nxt_irq_stat;
	logic [2:0] irq_ev;
	logic [15:0] speed_ff;
	logic fast_prev_ff;
	odopc_cc_state_t cc_state_ff;
	logic [7:0] c1_ff;
	logic [7:0] c2_ff;
	logic warn1_ff;
	logic warn2_ff;
	logic ctrl_wr;
	logic cmd_wr;
	logic sel_chg;
	logic shift_ev;
	logic adj_ev;
	logic step_ev;
	logic view_ok;

	odopc_win_if rate_if ();
	odopc_win_if speed_if ();

	// Inputs are qualified on their rising edge, so a held level counts once.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev1_ff <= 1'b0;
			prev2_ff <= 1'b0;
		end else begin
			prev1_ff <= odo1_in;
			prev2_ff <= odo2_in;
		end
	end

	assign q1 = odo1_in & ~prev1_ff;
	assign q2 = odo2_in & ~prev2_ff;

	// Register port decode.
	assign ctrl_wr = wr && (addr == `ODOPC_REG_CTRL);
	assign cmd_wr = wr && (addr == `ODOPC_REG_CMD);
	assign sel_chg = ctrl_wr && (wdata[`ODOPC_CTRL_SEL] != ctrl_ff[`ODOPC_CTRL_SEL]);
	assign shift_ev = cmd_wr && wdata[`ODOPC_CMD_SHIFT];
	assign adj_ev = cmd_wr && wdata[`ODOPC_CMD_ADJ];
	assign view_ok = ctrl_ff[`ODOPC_CTRL_SEL] && ctrl_ff[`ODOPC_CTRL_VIEW] && ctrl_ff[`ODOPC_CTRL_SHIFT];
	// Stepping is only reachable from the ratio view, as on the front panel.
	assign step_ev = cmd_wr && wdata[`ODOPC_CMD_STEP] && view_ok;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_ff <= `ODOPC_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_ff <= wdata[3:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ratio_ff <= `ODOPC_RATIO_RST;
		end else if (step_ev) begin
			ratio_ff <= ratio_ff + 3'h1;
		end
	end

	odopc_divider u_div (
		.clk(clk),
		.reset(reset),
		.ratio_code(ratio_ff),
		.restart(step_ev),
		.pulse_in(q2),
		.pulse_out(div2)
	);

	// The first input bypasses the divider entirely.
	assign active_pulse = ctrl_ff[`ODOPC_CTRL_SEL] ? div2 : q1;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dup_pulse_out <= 1'b0;
			count_pulse_out <= 1'b0;
		end else begin
			dup_pulse_out <= div2;
			count_pulse_out <= active_pulse;
		end
	end

	// Over-rate detection on the active input.
	assign rate_if.pulse = active_pulse;
	assign rate_if.limit = `ODOPC_RATE_LIMIT;

	odopc_window #(
		.WIN_CYC(RATE_WIN_CYC)
	) u_rate (
		.clk(clk),
		.reset(reset),
		.win(rate_if.cnt)
	);

	// Speed sampling uses the same counter on a shorter window; no limit applies.
	assign speed_if.pulse = active_pulse;
	assign speed_if.limit = 16'hFFFF;

	odopc_window #(
		.WIN_CYC(SPEED_WIN_CYC)
	) u_speed (
		.clk(clk),
		.reset(reset),
		.win(speed_if.cnt)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			speed_ff <= 16'h0000;
		end else if (speed_if.done) begin
			speed_ff <= speed_if.count;
		end
	end

	// The warning tracks the last full window, so it drops once a window comes in at or under the limit.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			too_fast_warning <= 1'b0;
			fast_prev_ff <= 1'b0;
		end else begin
			too_fast_warning <= rate_if.over;
			fast_prev_ff <= too_fast_warning;
		end
	end

	// Display indications.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ratio_show <= 1'b0;
			ratio_value <= 8'h01;
			factor_index <= 2'h0;
		end else begin
			ratio_show <= view_ok;
			ratio_value <= odopc_ratio_val(ratio_ff);
			factor_index <= {ctrl_ff[`ODOPC_CTRL_SEL], ctrl_ff[`ODOPC_CTRL_FSEL]};
		end
	end

	// Transducer cross-check. Correlation-phase counts saturate so a dead input cannot wrap into agreement.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cc_state_ff <= CC_IDLE;
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
			warn1_ff <= 1'b0;
			warn2_ff <= 1'b0;
		end else if (sel_chg) begin
			cc_state_ff <= CC_CORR;
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
			warn1_ff <= 1'b0;
			warn2_ff <= 1'b0;
		end else if (shift_ev || adj_ev) begin
			warn1_ff <= 1'b0;
			warn2_ff <= 1'b0;
			if (warn1_ff || warn2_ff) begin
				cc_state_ff <= CC_IDLE;
			end
		end else begin
			case (cc_state_ff)
				CC_IDLE: begin
					c1_ff <= 8'h00;
					c2_ff <= 8'h00;
				end
				CC_CORR: begin
					if (c1_ff >= `ODOPC_CORR_PULSES && c2_ff >= `ODOPC_CORR_PULSES) begin
						cc_state_ff <= CC_WATCH;
						c1_ff <= 8'h00;
						c2_ff <= 8'h00;
					end else begin
						if (q1 && c1_ff != 8'hFF) c1_ff <= c1_ff + 8'h01;
						if (div2 && c2_ff != 8'hFF) c2_ff <= c2_ff + 8'h01;
					end
				end
				CC_WATCH: begin
					if (c1_ff >= `ODOPC_CHECK_PULSES || c2_ff >= `ODOPC_CHECK_PULSES) begin
						c1_ff <= 8'h00;
						c2_ff <= 8'h00;
						if (c1_ff < `ODOPC_MISS_PULSES) begin
							warn1_ff <= 1'b1;
							cc_state_ff <= CC_IDLE;
						end else if (c2_ff < `ODOPC_MISS_PULSES) begin
							warn2_ff <= 1'b1;
							cc_state_ff <= CC_IDLE;
						end
					end else begin
						if (q1) c1_ff <= c1_ff + 8'h01;
						if (div2) c2_ff <= c2_ff + 8'h01;
					end
				end
				default: begin
					cc_state_ff <= CC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			first_source_failed_warning <= 1'b0;
			second_source_failed_warning <= 1'b0;
		end else begin
			first_source_failed_warning <= warn1_ff;
			second_source_failed_warning <= warn2_ff;
		end
	end

	// Interrupt: sticky status, write one to clear; a new event in the clearing cycle survives.
	assign irq_ev[`ODOPC_IRQ_FAST] = too_fast_warning && !fast_prev_ff;
	assign irq_ev[`ODOPC_IRQ_FAIL1] = warn1_ff && !first_source_failed_warning;
	assign irq_ev[`ODOPC_IRQ_FAIL2] = warn2_ff && !second_source_failed_warning;

	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (wr && addr == `ODOPC_REG_IRQ_STAT) begin
			nxt_irq_stat = nxt_irq_stat & ~wdata[2:0];
		end
		nxt_irq_stat = nxt_irq_stat | irq_ev;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_stat_ff <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq <= |(nxt_irq_stat & mask_ff);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mask_ff <= `ODOPC_MASK_RST;
		end else if (wr && addr == `ODOPC_REG_IRQ_MASK) begin
			mask_ff <= wdata[2:0];
		end
	end

	// Read data stand for exactly one cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				`ODOPC_REG_CTRL: rdata <= {28'h000_0000, ctrl_ff};
				`ODOPC_REG_STATUS: rdata <= {22'h00_0000, cc_state_ff, second_source_failed_warning,
					first_source_failed_warning, ratio_show, too_fast_warning, 1'b0, ratio_ff};
				`ODOPC_REG_IRQ_STAT: rdata <= {29'h0000_0000, irq_stat_ff};
				`ODOPC_REG_IRQ_MASK: rdata <= {29'h0000_0000, mask_ff};
				`ODOPC_REG_SPEED: rdata <= {16'h0000, speed_ff};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule // odopc_top

// ---- design/odopc_win_if.sv ----
/*
 * Carrier between the top and a windowed pulse counter.
 * Assumes one counter per instance and the top on the user side.
 */
interface odopc_win_if;
	logic pulse;
	logic [15:0] limit;
	logic [15:0] count;
	logic over;
	logic done;

	modport cnt (input pulse, input limit, output count, output over, output done);
	modport user (output pulse, output limit, input count, input over, input done);
endinterface

// ---- design/odopc_window.sv ----
/*
 * Counts pulses over a fixed window of clock cycles and reports the total and an over-limit flag.
 * Assumes one-cycle pulses; the count saturates rather than wrapping.
 */
module odopc_window #(
	parameter int WIN_CYC = 1000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Counter side of the carrier.
	odopc_win_if.cnt win
);
	logic [31:0] tick_ff;
	logic [15:0] acc_ff;
	logic [15:0] total;
	logic win_end;

	assign win_end = (tick_ff == 32'(WIN_CYC - 1));
	assign total = (win.pulse && acc_ff != 16'hFFFF) ? acc_ff + 16'h0001 : acc_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_ff <= 32'h0000_0000;
		end else if (win_end) begin
			tick_ff <= 32'h0000_0000;
		end else begin
			tick_ff <= tick_ff + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_ff <= 16'h0000;
			win.count <= 16'h0000;
			win.over <= 1'b0;
			win.done <= 1'b0;
		end else if (win_end) begin
			acc_ff <= 16'h0000;
			win.count <= total;
			win.over <= (total > win.limit);
			win.done <= 1'b1;
		end else begin
			acc_ff <= total;
			win.done <= 1'b0;
		end
	end
endmodule // odopc_window

// ---- tb/odopc_top_sva.sv ----
/*
 * Port checker of the odometer pulse conditioning top.
 * Assumes it is bound to odopc_top, one clock domain.
 */
`include "odopc_consts.svh"
module odopc_top_sva (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Watched ports.
	input wire logic odo1_in,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic dup_pulse_out,
	input wire logic count_pulse_out,
	input wire logic first_source_failed_warning,
	input wire logic second_source_failed_warning,
	input wire logic ratio_show,
	input wire logic [7:0] ratio_value,
	input wire logic [1:0] factor_index
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic in2;
	logic w1;
	logic w2;
	assign in2 = factor_index[1];
	assign w1 = first_source_failed_warning;
	assign w2 = second_source_failed_warning;
	a_ratio_pow_two: assert property ($onehot(ratio_value)) else $error("ratio not a power of two");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000) else $error("read data outside slot");
	a_dup_feeds_count: assert property (in2 && $past(in2) && $past(in2, 2) && dup_pulse_out |-> count_pulse_out)
		else $error("divided pulse not counted");
	a_dup_one_cycle: assert property (dup_pulse_out |=> !dup_pulse_out) else $error("divided pulse too long");
	a_show_needs_in2: assert property (ratio_show |-> in2) else $error("ratio shown for input one");
	a_in1_undivided: assert property ($rose(odo1_in) && !in2 ##1 !in2 |-> count_pulse_out)
		else $error("input one pulse lost");
	a_warn_one_side: assert property (!(w1 && w2)) else $error("both inputs suspected");
	a_warn_ack_clear: assert property (wr && addr == `ODOPC_REG_CMD && (wdata[1] || wdata[2]) |-> ##2 !w1 && !w2)
		else $error("warning kept after acknowledge");
	c_show_pulse: cover property (ratio_show && dup_pulse_out);
	c_warn_two: cover property (w2);
	c_warn_one: cover property (w1);
	c_in1_count: cover property (!in2 && count_pulse_out);
endmodule // odopc_top_sva
bind odopc_top odopc_top_sva u_sva (.clk(clk), .reset(reset), .odo1_in(odo1_in), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .dup_pulse_out(dup_pulse_out), .count_pulse_out(count_pulse_out),
	.first_source_failed_warning(first_source_failed_warning), .ratio_show(ratio_show),
	.second_source_failed_warning(second_source_failed_warning), .ratio_value(ratio_value),
	.factor_index(factor_index));

// ---- tb/odopc_top_tb.sv ----
/*
 * Self-checking bench of the odometer pulse conditioning top.
 * Assumes the transducer model and the bound checker are compiled before it.
 */
`include "odopc_consts.svh"
module odopc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] en = 2'b00;
	logic [7:0] per1 = 8'h02;
	logic [7:0] per2 = 8'h02;
	logic odo1_in, odo2_in, dup_pulse_out, count_pulse_out, too_fast_warning, w1, w2, ratio_show, irq;
	logic [31:0] rdata;
	logic [7:0] ratio_value;
	logic [1:0] factor_index;
	int errors = 0, n_compared = 0, cyc = 0, n_e1 = 0, n_e2 = 0, n_dup = 0, n_cnt = 0;
	always #2 clk = ~clk;
	odopc_top #(.RATE_WIN_CYC(12000), .SPEED_WIN_CYC(100)) DUT (.clk(clk), .reset(reset), .odo1_in(odo1_in),
		.odo2_in(odo2_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.dup_pulse_out(dup_pulse_out), .count_pulse_out(count_pulse_out), .too_fast_warning(too_fast_warning),
		.first_source_failed_warning(w1), .second_source_failed_warning(w2), .ratio_show(ratio_show),
		.ratio_value(ratio_value), .factor_index(factor_index), .irq(irq));
	odopc_xducer u_xd (.clk(clk), .reset(reset), .en(en), .per1(per1), .per2(per2), .odo1(odo1_in),
		.odo2(odo2_in));
	// Counting on the falling edge keeps the tally clear of the rising-edge updates.
	always @(negedge clk) begin
		n_e1 += int'(odo1_in === 1'b1);
		n_e2 += int'(odo2_in === 1'b1);
		n_dup += int'(dup_pulse_out === 1'b1);
		n_cnt += int'(count_pulse_out === 1'b1);
	end
	function automatic int div_of(input int code);
		return 1 << code;
	endfunction
	task automatic report_and_stop();
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic run(input logic [1:0] e, input int m);
		int base;
		base = e[1] ? n_e2 : n_e1;
		@(posedge clk);
		en <= e;
		while ((e[1] ? n_e2 : n_e1) - base < m) @(posedge clk);
		en <= 2'b00;
		repeat (6) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		int m, n, d0, c0, e1;
		void'($urandom(32'h665d_6d96));
		repeat (4) @(posedge clk);
		chk(32'(ratio_value), 32'h0000_0001);
		reset <= 1'b0;
		rreg(`ODOPC_REG_STATUS, 32'h0000_0000);
		rreg(`ODOPC_REG_IRQ_MASK, 32'h0000_0000);
		rreg(`ODOPC_REG_CMD, 32'h0000_0000);
		rreg(8'h18, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			wreg(`ODOPC_REG_CTRL, 32'({k[0], k[1]}));
			chk(32'(factor_index), 32'(k));
			rreg(`ODOPC_REG_CTRL, 32'({k[0], k[1]}));
		end
		wreg(`ODOPC_REG_CTRL, 32'h0000_000D);
		chk(32'(ratio_show), 32'h0000_0001);
		for (int k = 0; k < 9; k++) begin
			n = div_of(k % 8);
			chk(32'(ratio_value), 32'(n));
			rreg(`ODOPC_REG_STATUS, 32'h0000_0120 | 32'(k % 8));
			per2 <= 8'(2 + $urandom_range(2));
			m = 2 * n + int'($urandom_range(n - 1));
			d0 = n_dup;
			c0 = n_cnt;
			run(2'b10, m);
			chk(32'(n_dup - d0), 32'(m / n));
			chk(32'(n_cnt - c0), 32'(m / n));
			wreg(`ODOPC_REG_CMD, 32'h0000_0001);
		end
		// Stepping outside the ratio view must be refused.
		wreg(`ODOPC_REG_CTRL, 32'h0000_0009);
		chk(32'(ratio_show), 32'h0000_0000);
		wreg(`ODOPC_REG_CMD, 32'h0000_0001);
		chk(32'(ratio_value), 32'h0000_0002);
		wreg(`ODOPC_REG_CTRL, 32'h0000_0000);
		d0 = n_dup;
		c0 = n_cnt;
		e1 = n_e1;
		run(2'b11, 10);
		chk(32'(n_dup - d0), 32'h0000_0005);
		chk(32'(n_cnt - c0), 32'(n_e1 - e1));
		wreg(`ODOPC_REG_CTRL, 32'h0000_0001);
		run(2'b01, 100);
		chk(32'({w1, w2}), 32'h0000_0000);
		rreg(`ODOPC_REG_STATUS, 32'h0000_0101);
		per2 <= 8'h02;
		run(2'b11, 120);
		run(2'b01, 70);
		chk(32'({w1, w2}), 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		rreg(`ODOPC_REG_IRQ_STAT, 32'h0000_0004);
		wreg(`ODOPC_REG_IRQ_MASK, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		wreg(`ODOPC_REG_CMD, 32'h0000_0002);
		chk(32'({w1, w2}), 32'h0000_0000);
		rreg(`ODOPC_REG_STATUS, 32'h0000_0001);
		wreg(`ODOPC_REG_IRQ_STAT, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0000);
		run(2'b11, 120);
		run(2'b01, 70);
		chk(32'({w1, w2}), 32'h0000_0000);
		wreg(`ODOPC_REG_CTRL, 32'h0000_0000);
		rreg(`ODOPC_REG_STATUS, 32'h0000_0101);
		// Correlate both inputs, then lose input one so that it is the one suspected.
		run(2'b11, 120);
		run(2'b10, 130);
		chk(32'({w1, w2}), 32'h0000_0002);
		rreg(`ODOPC_REG_IRQ_STAT, 32'h0000_0002);
		wreg(`ODOPC_REG_CMD, 32'h0000_0004);
		chk(32'({w1, w2}), 32'h0000_0000);
		rreg(`ODOPC_REG_STATUS, 32'h0000_0001);
		wreg(`ODOPC_REG_IRQ_STAT, 32'h0000_0002);
		wreg(`ODOPC_REG_CTRL, 32'h0000_0001);
		rreg(`ODOPC_REG_STATUS, 32'h0000_0101);
		wreg(`ODOPC_REG_CTRL, 32'h0000_0000);
		// Two full windows at each rate, since the windows run free from reset.
		@(posedge clk);
		en <= 2'b01;
		repeat (26000) @(posedge clk);
		#1;
		chk(32'(too_fast_warning), 32'h0000_0001);
		rreg(`ODOPC_REG_SPEED, 32'h0000_0032);
		rreg(`ODOPC_REG_IRQ_STAT, 32'h0000_0001);
		per1 <= 8'h03;
		repeat (26000) @(posedge clk);
		#1;
		chk(32'(too_fast_warning), 32'h0000_0000);
		report_and_stop();
	end
endmodule // odopc_top_tb

// ---- tb/odopc_xducer.sv ----
/*
 * Behavioural pair of pulse transducers facing the conditioning block.
 * Assumes the bench sets each period to two cycles or more.
 */
module odopc_xducer (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Control from the bench.
	input wire logic [1:0] en,
	input wire logic [7:0] per1,
	input wire logic [7:0] per2,
	// Pulse lines.
	output logic odo1,
	output logic odo2
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] c1_ff;
	logic [7:0] c2_ff;
	// A stopped sensor rests low, so an idle input never shows a stale high.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
			odo1 <= 1'b0;
			odo2 <= 1'b0;
		end else begin
			c1_ff <= (c1_ff >= per1 - 8'h01) ? 8'h00 : c1_ff + 8'h01;
			c2_ff <= (c2_ff >= per2 - 8'h01) ? 8'h00 : c2_ff + 8'h01;
			odo1 <= en[0] && c1_ff == 8'h00;
			odo2 <= en[1] && c2_ff == 8'h00;
		end
	end
endmodule // odopc_xducer
